// *** rtl/hrs_map.svh ***
/*
 Register offsets, field positions, reset values and timing counts
 of the hot-runner setpoint sequencer. Assumes a 20 MHz pclk.
*/
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH
`define HRS_CTRL 12'h000
`define HRS_SP 12'h004
`define HRS_SP2 12'h008
`define HRS_SP_SU 12'h00C
`define HRS_SP_ACT 12'h010
`define HRS_BOOST_INC 12'h014
`define HRS_TIMES 12'h018
`define HRS_RAMP 12'h01C
`define HRS_FACTORS 12'h020
`define HRS_FILTER 12'h024
`define HRS_STATUS 12'h028
`define HRS_SETPOINTS 12'h02C
`define HRS_LAST_IDX 4'hB
// control word fields
`define HRS_C_HOTR 0
`define HRS_C_STARTUP_ENABLE 1
`define HRS_C_DERIVATIVE_PI_TYPE 2
`define HRS_C_BOOST 3
`define HRS_C_TUNE 4
`define HRS_C_STEP 5
`define HRS_C_MAN 6
`define HRS_C_SP2 7
`define HRS_C_OFF 8
`define HRS_C_BIF_LO 9
`define HRS_C_W 11
`define HRS_CTRL_RST 11'h000
// temperatures in 0.1 degree, factors in percent
`define HRS_SU_MARGIN 18'sh00014
`define HRS_SU_DROP 18'sh00190
`define HRS_MV_MAX 10'sh064
`define HRS_RAMP_DIV 24'h000258
`define HRS_FILT_MIN 16'h0003
`define HRS_FILT_MAX 16'h00FA
`define HRS_SU_FACTOR_RST 8'h0A
`define HRS_CYCLE_RST 16'h000A
// timing
`define HRS_CLK_HZ 20000000
`define HRS_PULSE_MS 100
`define HRS_TICK_CYC (`HRS_CLK_HZ / 1000 * `HRS_PULSE_MS)
`define HRS_TICKS_PER_S 4'h9
`define HRS_SLOTS 7'h63
`endif

// *** rtl/hrs_pkg.sv ***
/*
 Types of the hot-runner setpoint sequencer.
 Takes no constants from hrs_map.svh; the enum encodings are defined here.
*/
package hrs_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_STARTUP = 4'h2,
        ST_DWELL = 4'h4,
        ST_RUN = 4'h8
    } su_state_t;
    typedef enum logic [1:0] {
        BI_NONE = 2'h0,
        BI_STARTUP = 2'h1,
        BI_BOOST = 2'h2,
        BI_FEEDFWD = 2'h3
    } bin_func_t;
    typedef enum logic [1:0] {
        MK_NONE = 2'h0,
        MK_RAMP = 2'h1,
        MK_BOOST = 2'h2
    } marker_t;
endpackage : hrs_pkg

// *** rtl/hot_runner_setpoint_sequencer.sv ***
/*
 Setpoint and manipulated-variable sequencer with APB register slave.
 Assumes a PID core feeding pid_mv and a sensor feeding actual_value,
 both synchronous to pclk; temperatures in signed 0.1 degree steps.
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "hrs_map.svh"

module hot_runner_setpoint_sequencer #(
    parameter int TICK_CYCLES = `HRS_TICK_CYC
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // process side
    input wire logic [15:0] actual_value,
    input wire logic [7:0] pid_mv,
    input wire logic binary_in,
    // actuator, control and display
    output logic heat_pulse,
    output logic [7:0] mv_out,
    output logic [15:0] control_sp,
    output logic [15:0] limit_ref_sp,
    output logic [15:0] display_sp,
    output logic [1:0] display_marker,
    output logic filter_enable
);
    typedef struct packed {
        logic [`HRS_C_W-1:0] ctrl;
        logic [15:0] sp;
        logic [15:0] sp2;
        logic [15:0] sp_su;
        logic [15:0] sp_act;
        logic [15:0] boost_inc;
        logic [9:0] dwell_s;
        logic [9:0] boost_s;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [7:0] su_factor;
        logic [7:0] feedforward_offset;
        logic [15:0] oscillation_period;
        logic [15:0] cycle_time;
        hrs_pkg::su_state_t st;
        logic first;
        logic [31:0] tick_cnt;
        logic [3:0] dwell_tenth;
        logic [3:0] boost_tenth;
        logic [9:0] dwell_cnt;
        logic [9:0] boost_cnt;
        logic boosting;
        logic trig_prev;
        logic [15:0] ramp_sp;
        logic [23:0] ramp_acc;
        logic [15:0] prev_target;
        logic prev_sp2;
        logic prev_man;
        logic [31:0] slot_len;
        logic [15:0] sub;
        logic [6:0] slot;
        logic heat;
        logic [7:0] mv;
        logic [15:0] ctl_sp;
        logic [15:0] lim_sp;
        logic [15:0] disp_sp;
        hrs_pkg::marker_t marker;
        logic filt;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } state_t;

    state_t s_q, s_d;

    // act below ref minus margin, widened so no wrap
    function automatic logic below(input logic [15:0] act, input logic [15:0] ref_v,
                                   input logic signed [17:0] margin);
        below = $signed({{2{act[15]}}, act}) < ($signed({{2{ref_v[15]}}, ref_v}) - margin);
    endfunction : below

    function automatic logic [7:0] sat_mv(input logic signed [9:0] v);
        if (v > `HRS_MV_MAX) begin
            sat_mv = 8'(`HRS_MV_MAX);
        end else if (v < -`HRS_MV_MAX) begin
            sat_mv = 8'(-`HRS_MV_MAX);
        end else begin
            sat_mv = v[7:0];
        end
    endfunction : sat_mv

    logic tick, sec_tick, boost_sec, su_en, trig, ff_on, restart, wr, mapped;
    logic [15:0] target;
    logic [3:0] idx;
    hrs_pkg::bin_func_t bif;
    logic signed [9:0] mv_c;

    always_comb begin
        s_d = s_q;
        s_d.first = 1'b0;
        bif = hrs_pkg::bin_func_t'(s_q.ctrl[`HRS_C_BIF_LO +: 2]);
        idx = paddr[5:2];
        mapped = (paddr[11:6] == 6'h00) && (idx <= `HRS_LAST_IDX) && (paddr[1:0] == 2'h0);
        // tenth-second tick and whole seconds
        tick = (s_q.tick_cnt == 32'(TICK_CYCLES - 1));
        s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;
        // own tenths per timer, so a freshly entered phase counts a full first second
        sec_tick = tick && (s_q.dwell_tenth == `HRS_TICKS_PER_S);
        boost_sec = tick && (s_q.boost_tenth == `HRS_TICKS_PER_S);
        if (tick) begin
            s_d.dwell_tenth = sec_tick ? 4'h0 : s_q.dwell_tenth + 4'h1;
            s_d.boost_tenth = boost_sec ? 4'h0 : s_q.boost_tenth + 4'h1;
        end

        // register writes take effect on the access edge
        wr = psel && penable && s_q.rdy && pwrite && mapped;
        if (wr) begin
            case ({paddr[11:2], 2'h0})
                `HRS_CTRL: s_d.ctrl = pwdata[`HRS_C_W-1:0];
                `HRS_SP: s_d.sp = pwdata[15:0];
                `HRS_SP2: s_d.sp2 = pwdata[15:0];
                `HRS_SP_SU: s_d.sp_su = pwdata[15:0];
                `HRS_SP_ACT: s_d.sp_act = pwdata[15:0];
                `HRS_BOOST_INC: s_d.boost_inc = pwdata[15:0];
                `HRS_TIMES: begin
                    s_d.dwell_s = pwdata[9:0];
                    s_d.boost_s = pwdata[25:16];
                end
                `HRS_RAMP: begin
                    s_d.rise = pwdata[15:0];
                    s_d.fall = pwdata[31:16];
                end
                `HRS_FACTORS: begin
                    s_d.su_factor = pwdata[7:0];
                    s_d.feedforward_offset = pwdata[15:8];
                end
                `HRS_FILTER: begin
                    s_d.oscillation_period = pwdata[15:0];
                    s_d.cycle_time = pwdata[31:16];
                end
                default: ;
            endcase
        end

        // start-up sequence
        su_en = s_q.ctrl[`HRS_C_HOTR] && s_q.ctrl[`HRS_C_DERIVATIVE_PI_TYPE] &&
                (s_q.ctrl[`HRS_C_STARTUP_ENABLE] ||
                 (bif == hrs_pkg::BI_STARTUP && binary_in));
        if (sec_tick && s_q.dwell_cnt != 10'h3FF) begin
            s_d.dwell_cnt = s_q.dwell_cnt + 10'h001;
        end
        case (s_q.st)
            hrs_pkg::ST_IDLE: begin
                if (su_en && below(actual_value, s_q.sp_su, `HRS_SU_MARGIN)) begin
                    s_d.st = hrs_pkg::ST_STARTUP;
                end else begin
                    s_d.st = hrs_pkg::ST_RUN;
                end
            end
            hrs_pkg::ST_STARTUP: begin
                // no timeout: stays here while the exit is unreachable
                if (!su_en) begin
                    s_d.st = hrs_pkg::ST_RUN;
                end else if (below(s_q.sp_su, actual_value, -`HRS_SU_MARGIN)) begin
                    s_d.st = hrs_pkg::ST_DWELL;
                    s_d.dwell_cnt = 10'h000;
                    s_d.dwell_tenth = 4'h0;
                end
            end
            hrs_pkg::ST_DWELL, hrs_pkg::ST_RUN: begin
                if (su_en && below(actual_value, s_q.sp_su, `HRS_SU_DROP)) begin
                    s_d.st = hrs_pkg::ST_STARTUP;
                end else if (s_q.st == hrs_pkg::ST_DWELL &&
                             (!su_en || s_q.dwell_cnt >= s_q.dwell_s)) begin
                    s_d.st = hrs_pkg::ST_RUN;
                end
            end
            default: s_d.st = hrs_pkg::ST_IDLE;
        endcase
        if (s_q.ctrl[`HRS_C_OFF]) begin
            s_d.st = hrs_pkg::ST_IDLE;
        end

        // boost
        trig = s_q.ctrl[`HRS_C_BOOST] || (bif == hrs_pkg::BI_BOOST && binary_in);
        s_d.trig_prev = trig;
        if (boost_sec && s_q.boost_cnt != 10'h3FF) begin
            s_d.boost_cnt = s_q.boost_cnt + 10'h001;
        end
        if (!s_q.boosting && trig && !s_q.trig_prev && s_q.ctrl[`HRS_C_HOTR]) begin
            s_d.boosting = 1'b1;
            s_d.boost_cnt = 10'h000;
            s_d.boost_tenth = 4'h0;
        end else if (s_q.boosting && (!trig || s_q.boost_cnt >= s_q.boost_s ||
                                      !s_q.ctrl[`HRS_C_HOTR])) begin
            s_d.boosting = 1'b0;
        end

        // setpoint ramp, toward the unboosted target
        target = s_q.ctrl[`HRS_C_SP2] ? s_q.sp2 : s_q.sp;
        s_d.prev_target = target;
        s_d.prev_sp2 = s_q.ctrl[`HRS_C_SP2];
        s_d.prev_man = s_q.ctrl[`HRS_C_MAN];
        restart = s_q.first || (target != s_q.prev_target) ||
                  (s_q.ctrl[`HRS_C_SP2] && !s_q.prev_sp2) ||
                  (!s_q.ctrl[`HRS_C_MAN] && s_q.prev_man);
        if (restart) begin
            s_d.ramp_sp = actual_value;
            s_d.ramp_acc = 24'h000000;
        end else if ($signed(target) > $signed(s_q.ramp_sp)) begin
            if (s_q.rise == 16'h0000) begin
                s_d.ramp_sp = target;
            end else if (s_q.ramp_acc >= `HRS_RAMP_DIV) begin
                s_d.ramp_sp = s_q.ramp_sp + 16'h0001;
                s_d.ramp_acc = s_q.ramp_acc - `HRS_RAMP_DIV;
            end else if (tick) begin
                s_d.ramp_acc = s_q.ramp_acc + {8'h00, s_q.rise};
            end
        end else if ($signed(target) < $signed(s_q.ramp_sp)) begin
            if (s_q.fall == 16'h0000) begin
                s_d.ramp_sp = target;
            end else if (s_q.ramp_acc >= `HRS_RAMP_DIV) begin
                s_d.ramp_sp = s_q.ramp_sp - 16'h0001;
                s_d.ramp_acc = s_q.ramp_acc - `HRS_RAMP_DIV;
            end else if (tick) begin
                s_d.ramp_acc = s_q.ramp_acc + {8'h00, s_q.fall};
            end
        end else begin
            s_d.ramp_acc = 24'h000000;
        end

        // setpoints to control, limits and display
        case (s_q.st)
            hrs_pkg::ST_STARTUP: s_d.ctl_sp = s_q.sp_su;
            hrs_pkg::ST_DWELL: s_d.ctl_sp = s_q.sp_act;
            default: s_d.ctl_sp = s_q.ramp_sp + (s_q.boosting ? s_q.boost_inc : 16'h0000);
        endcase
        s_d.lim_sp = s_q.ramp_sp;
        s_d.disp_sp = target;
        if (s_q.boosting) begin
            s_d.marker = hrs_pkg::MK_BOOST;
        end else if (s_q.ramp_sp != target) begin
            s_d.marker = hrs_pkg::MK_RAMP;
        end else begin
            s_d.marker = hrs_pkg::MK_NONE;
        end
        s_d.filt = (s_q.oscillation_period >= `HRS_FILT_MIN) &&
                   (s_q.oscillation_period <= `HRS_FILT_MAX);

        // manipulated variable
        ff_on = (bif == hrs_pkg::BI_FEEDFWD) && !s_q.ctrl[`HRS_C_TUNE] &&
                !s_q.ctrl[`HRS_C_STEP];
        mv_c = {{2{pid_mv[7]}}, pid_mv};
        if (ff_on) begin
            mv_c = binary_in ? mv_c + {{2{s_q.feedforward_offset[7]}}, s_q.feedforward_offset}
                             : mv_c - {{2{s_q.feedforward_offset[7]}}, s_q.feedforward_offset};
        end
        if (s_q.st == hrs_pkg::ST_STARTUP && mv_c > $signed({{2{s_q.su_factor[7]}}, s_q.su_factor})) begin
            mv_c = {{2{s_q.su_factor[7]}}, s_q.su_factor};
        end
        s_d.mv = s_q.ctrl[`HRS_C_OFF] ? 8'h00 : sat_mv(mv_c);

        // pulse output: 100 slots per period; hot runner fixes the period at one tick
        s_d.slot_len = s_q.slot_len + 32'h0000_0001;
        if (s_q.slot_len >= 32'(TICK_CYCLES / 100 - 1)) begin
            s_d.slot_len = 32'h0000_0000;
            if (s_q.ctrl[`HRS_C_HOTR] || s_q.sub + 16'h0001 >= s_q.cycle_time) begin
                s_d.sub = 16'h0000;
                s_d.slot = (s_q.slot >= `HRS_SLOTS) ? 7'h00 : s_q.slot + 7'h01;
            end else begin
                s_d.sub = s_q.sub + 16'h0001;
            end
        end
        s_d.heat = !s_q.mv[7] && (s_q.mv > {1'b0, s_q.slot});

        // apb: data prepared in setup, ready in the first access cycle
        s_d.rdy = psel && !penable;
        s_d.err = psel && !penable && !mapped;
        s_d.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite && mapped) begin
            case ({paddr[11:2], 2'h0})
                `HRS_CTRL: s_d.rdata = 32'(s_q.ctrl);
                `HRS_SP: s_d.rdata = {16'h0000, s_q.sp};
                `HRS_SP2: s_d.rdata = {16'h0000, s_q.sp2};
                `HRS_SP_SU: s_d.rdata = {16'h0000, s_q.sp_su};
                `HRS_SP_ACT: s_d.rdata = {16'h0000, s_q.sp_act};
                `HRS_BOOST_INC: s_d.rdata = {16'h0000, s_q.boost_inc};
                `HRS_TIMES: s_d.rdata = {6'h00, s_q.boost_s, 6'h00, s_q.dwell_s};
                `HRS_RAMP: s_d.rdata = {s_q.fall, s_q.rise};
                `HRS_FACTORS: s_d.rdata = {16'h0000, s_q.feedforward_offset, s_q.su_factor};
                `HRS_FILTER: s_d.rdata = {s_q.cycle_time, s_q.oscillation_period};
                `HRS_STATUS: s_d.rdata = {20'h00000, s_q.filt, s_q.marker,
                                          s_q.boosting, s_q.heat, 3'h0, s_q.st};
                `HRS_SETPOINTS: s_d.rdata = {s_q.ctl_sp, s_q.ramp_sp};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= hrs_pkg::ST_IDLE;
            s_q.first <= 1'b1;
            s_q.ctrl <= `HRS_CTRL_RST;
            s_q.su_factor <= `HRS_SU_FACTOR_RST;
            s_q.cycle_time <= `HRS_CYCLE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.rdy;
    assign pslverr = s_q.err;
    assign heat_pulse = s_q.heat;
    assign mv_out = s_q.mv;
    assign control_sp = s_q.ctl_sp;
    assign limit_ref_sp = s_q.lim_sp;
    assign display_sp = s_q.disp_sp;
    assign display_marker = s_q.marker;
    assign filter_enable = s_q.filt;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_su_type;
        s_q.st == hrs_pkg::ST_STARTUP |-> $past(s_q.ctrl[`HRS_C_DERIVATIVE_PI_TYPE] && s_q.ctrl[`HRS_C_HOTR]);
    endproperty
    a_su_type: assert property (p_su_type) else $error("start-up without derivative_pi_type");
    property p_su_clamp;
        s_q.st == hrs_pkg::ST_STARTUP && !s_q.ctrl[`HRS_C_OFF]
            |=> $signed(mv_out) <= $signed($past(s_q.su_factor));
    endproperty
    a_su_clamp: assert property (p_su_clamp) else $error("start-up mv not clamped");
    property p_su_exit;
        s_q.st == hrs_pkg::ST_STARTUP && su_en && !s_q.ctrl[`HRS_C_OFF] &&
            $signed(actual_value) > $signed(s_q.sp_su) - 20 |=> s_q.st == hrs_pkg::ST_DWELL;
    endproperty
    a_su_exit: assert property (p_su_exit) else $error("start-up did not end");
    property p_su_restart;
        s_q.st == hrs_pkg::ST_RUN && su_en && !s_q.ctrl[`HRS_C_OFF] &&
            below(actual_value, s_q.sp_su, `HRS_SU_DROP) |=> s_q.st == hrs_pkg::ST_STARTUP;
    endproperty
    a_su_restart: assert property (p_su_restart) else $error("no start-up restart");
    property p_boost_stop;
        s_q.boosting && !trig |=> !s_q.boosting;
    endproperty
    a_boost_stop: assert property (p_boost_stop) else $error("boost kept after clear");
    property p_filter;
        filter_enable |-> $past(s_q.oscillation_period) inside {[3:250]};
    endproperty
    a_filter: assert property (p_filter) else $error("filter enabled out of range");
    property p_ramp_disp;
        !s_q.boosting && s_q.ramp_sp != target
            |=> display_marker == hrs_pkg::MK_RAMP && display_sp == $past(target);
    endproperty
    a_ramp_disp: assert property (p_ramp_disp) else $error("ramp display wrong");
    property p_limit_ref;
        1'b1 |=> limit_ref_sp == $past(s_q.ramp_sp);
    endproperty
    a_limit_ref: assert property (p_limit_ref) else $error("limit reference wrong");
    property p_tune_no_ff;
        s_q.ctrl[`HRS_C_TUNE] && s_q.st != hrs_pkg::ST_STARTUP && !s_q.ctrl[`HRS_C_OFF]
            |=> mv_out == $past(sat_mv({{2{pid_mv[7]}}, pid_mv}));
    endproperty
    a_tune_no_ff: assert property (p_tune_no_ff) else $error("feed-forward during tuning");
    c_startup: cover property (s_q.st == hrs_pkg::ST_STARTUP ##1 s_q.st == hrs_pkg::ST_DWELL);
    c_boost: cover property (s_q.boosting ##1 !s_q.boosting);
    c_ramp: cover property (display_marker == hrs_pkg::MK_RAMP);
endmodule : hot_runner_setpoint_sequencer

// *** test/process_loop_model.sv ***
/*
 Process loop partner: heater driven by heat_pulse, sensor giving actual_value.
 Assumes the bench may force the sensor to a target for prompt answers.
*/
module process_loop_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // heater and bench control
    input wire logic heat_pulse,
    input wire logic force_en,
    input wire logic [15:0] target,
    // sensor
    output logic [15:0] actual_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] temp_q;
    // slow path: one step per clock while the heater is on, cools when the heater is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            temp_q <= 16'h03E8;
        end else if (force_en) begin
            temp_q <= target;
        end else if (heat_pulse && $signed(temp_q) < $signed(target)) begin
            temp_q <= temp_q + 16'h0001;
        end else if (!heat_pulse && $signed(temp_q) > $signed(target)) begin
            temp_q <= temp_q - 16'h0001;
        end
    end
    assign actual_value = temp_q;
endmodule : process_loop_model

// *** test/tb_top.sv ***
/*
 Self-checking bench of the setpoint sequencer over APB.
 Assumes hrs_map.svh and the process loop model; TICK_CYCLES cut to 200.
*/
`include "hrs_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, binary_in = 1'b0, force_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, heat_pulse, filter_enable;
    logic [7:0] pid_mv = 8'h00;
    logic [7:0] mv_out;
    logic [15:0] target = 16'h03E8;
    logic [15:0] actual_value, control_sp, limit_ref_sp, display_sp;
    logic [1:0] display_marker;
    int num_errors = 0, n_checks = 0, cycles = 0;
    always #25 pclk = ~pclk;
    hot_runner_setpoint_sequencer #(.TICK_CYCLES(TICK)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .actual_value(actual_value),
        .pid_mv(pid_mv), .binary_in(binary_in), .heat_pulse(heat_pulse), .mv_out(mv_out),
        .control_sp(control_sp), .limit_ref_sp(limit_ref_sp), .display_sp(display_sp),
        .display_marker(display_marker), .filter_enable(filter_enable));
    process_loop_model i_loop (.clk(pclk), .rst_n(presetn), .heat_pulse(heat_pulse),
        .force_en(force_en), .target(target), .actual_value(actual_value));
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask : rd
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask : cyc
    task automatic wait_ramp();
        int n;
        n = 0;
        while (display_marker === 2'h1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        cyc(2);
    endtask : wait_ramp
    // polls the state field; bounded so a stuck sequencer cannot hang the run
    task automatic wait_st(input logic [3:0] s);
        int n;
        n = 0;
        do begin
            rd(`HRS_STATUS);
            n++;
        end while (q[3:0] !== s && n < 8000);
        chk({28'h0000000, q[3:0]}, {28'h0000000, s});
    endtask : wait_st
    function automatic int sat(input int a);
        return a > 100 ? 100 : (a < -100 ? -100 : a);
    endfunction : sat
    initial begin
        int i, m, b, x;
        int fv[5] = '{2, 3, 250, 251, 0};
        int st[2] = '{1000, 1300};
        int tg[2] = '{1200, 1100};
        x = $urandom(65308);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`HRS_CTRL);
        chk(q, 32'h00000000);
        rd(`HRS_FACTORS);
        chk(q, 32'h0000000A);
        rd(`HRS_FILTER);
        chk(q, 32'h000A0000);
        rd(12'h030);
        chk({31'h0, e}, 32'h00000001);
        chk(q, 32'h00000000);
        rd(12'h006);
        chk({31'h0, e}, 32'h00000001);
        for (i = 0; i < 5; i++) begin
            x = (i == 4) ? int'($urandom_range(250, 3)) : fv[i];
            wr(`HRS_FILTER, {16'h000A, x[15:0]});
            cyc(3);
            chk({31'h0, filter_enable}, {31'h0, x >= 3 && x <= 250});
        end
        wr(`HRS_FACTORS, 32'h0000140A);
        for (i = 0; i < 9; i++) begin
            m = i % 3;
            b = $urandom_range(1);
            x = int'($urandom_range(120)) - 60;
            pid_mv <= x[7:0];
            binary_in <= b[0];
            wr(`HRS_CTRL, 32'h00000600 | (m == 1 ? 32'h10 : (m == 2 ? 32'h20 : 32'h0)));
            cyc(4);
            x = (m != 0) ? x : sat(b != 0 ? x + 20 : x - 20);
            chk({24'h000000, mv_out}, {24'h000000, x[7:0]});
        end
        binary_in <= 1'b0;
        wr(`HRS_SP, 32'h000003E8);
        wr(`HRS_BOOST_INC, 32'h00000032);
        wr(`HRS_TIMES, 32'h00010000);
        wr(`HRS_CTRL, 32'h00000001);
        wr(`HRS_CTRL, 32'h00000009);
        cyc(4);
        chk({30'h0, display_marker}, 32'h00000002);
        chk({16'h0000, display_sp}, 32'h000003E8);
        chk({16'h0000, control_sp}, 32'h0000041A);
        cyc(1746);
        chk({30'h0, display_marker}, 32'h00000002);
        cyc(400);
        chk({30'h0, display_marker}, 32'h00000000);
        chk({16'h0000, control_sp}, 32'h000003E8);
        wr(`HRS_CTRL, 32'h00000001);
        wr(`HRS_CTRL, 32'h00000009);
        cyc(4);
        chk({30'h0, display_marker}, 32'h00000002);
        wr(`HRS_CTRL, 32'h00000001);
        cyc(3);
        chk({30'h0, display_marker}, 32'h00000000);
        wr(`HRS_CTRL, 32'h00000008);
        cyc(4);
        chk({30'h0, display_marker}, 32'h00000000);
        wr(`HRS_SP_SU, 32'h000007D0);
        wr(`HRS_SP_ACT, 32'h00000708);
        wr(`HRS_TIMES, 32'h00000001);
        pid_mv <= 8'h32;
        binary_in <= 1'b1;
        wr(`HRS_CTRL, 32'h00000103);
        wr(`HRS_CTRL, 32'h00000003);
        rd(`HRS_STATUS);
        chk({31'h0, q[1]}, 32'h00000000);
        wr(`HRS_CTRL, 32'h00000305);
        wr(`HRS_CTRL, 32'h00000205);
        wait_st(4'h2);
        cyc(3);
        chk({24'h000000, mv_out}, 32'h0000000A);
        chk({16'h0000, control_sp}, 32'h000007D0);
        x = 0;
        // cycle time of one second is set, the pulse train must still follow the tick
        repeat (TICK) begin
            @(posedge pclk);
            x += int'(heat_pulse);
        end
        chk(x, 32'h00000014);
        force_en <= 1'b0;
        target <= 16'h0834;
        wait_st(4'h4);
        chk({31'h0, actual_value > 16'h07BC}, 32'h00000001);
        chk({16'h0000, control_sp}, 32'h00000708);
        cyc(1700);
        wait_st(4'h4);
        wait_st(4'h8);
        chk({16'h0000, control_sp}, 32'h000003E8);
        force_en <= 1'b1;
        target <= 16'h0641;
        cyc(5);
        wait_st(4'h8);
        target <= 16'h063F;
        wait_st(4'h2);
        cyc(2500);
        rd(`HRS_STATUS);
        chk({28'h0000000, q[3:0]}, 32'h00000002);
        wr(`HRS_CTRL, 32'h00000000);
        wr(`HRS_RAMP, 32'h17701770);
        for (i = 0; i < 2; i++) begin
            target <= st[i][15:0];
            cyc(3);
            wr(`HRS_SP, tg[i]);
            cyc(4);
            chk({30'h0, display_marker}, 32'h00000001);
            chk({16'h0000, display_sp}, tg[i]);
            chk({16'h0000, control_sp}, {16'h0000, limit_ref_sp});
            chk({31'h0, limit_ref_sp != tg[i][15:0]}, 32'h00000001);
            wait_ramp();
            chk({16'h0000, limit_ref_sp}, tg[i]);
        end
        // same value in both setpoints: the selection edge and the end of manual mode restart the ramp
        target <= 16'h03E8;
        wr(`HRS_SP2, 32'h0000044C);
        wr(`HRS_CTRL, 32'h00000080);
        cyc(4);
        chk({30'h0, display_marker}, 32'h00000001);
        wait_ramp();
        chk({16'h0000, limit_ref_sp}, 32'h0000044C);
        wr(`HRS_CTRL, 32'h000000C0);
        wr(`HRS_CTRL, 32'h00000080);
        cyc(4);
        chk({30'h0, display_marker}, 32'h00000001);
        chk({16'h0000, display_sp}, 32'h0000044C);
        wrap_up();
    end
endmodule : tb_top
